// [src/uv_oc_fault_limit_response.sv]
// Fault limit and response registers with the fault shutdown and retry sequencer
// Overview of operation
// - Undervoltage action: ignore, delayed or immediate shutdown
// - Retry zero latches off after shutdown
// - Retry 1-6 restarts that often, then latches
// - Retry seven restarts without limit
// - Delay 0-1: one tick, one rise time
// - Delay 2-4: three ticks, value times rise
// - Delay 5-7: seven ticks, value times rise
// - Invalid writes rejected, data error flagged
// - Stack limit is lowest phase times count
// - Limit word: exponent 15:11, mantissa 10:0
// - Accept 62A per phase stacked, 31A single
// - Threshold 4A to 31A, round up
// - Below 4A applied as 4A
// - Restore clamps each phase limit to 31A max
// - All-phase write divides by phase count
// - All-phase read is phase zero times count
// - Single-phase access touches only that phase
// - Overcurrent sets its status bits, alerts host
// - Byte commands 45h/47h, word command 46h
// - Overcurrent action: ignore, delayed, immediate
// - Undervoltage sets its status bits, alerts host
`timescale 1ns/1ns
module uv_oc_fault_limit_response #(
    parameter int unsigned RISE_CYCLES = uv_oc_pkg::SOFT_START_RISE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        linkClk,
    input  wire logic        cmdValid,
    input  wire logic        cmdWrite,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [7:0]  cmdPhase,
    input  wire logic [15:0] cmdData,
    output logic             cmdBusy,
    output logic             rspValid,
    output logic             rspError,
    output logic [15:0]      rspData,
    input  wire logic [1:0]  phaseCountPin,
    input  wire logic        powerEnablePin,
    input  wire logic        uvFaultPin,
    input  wire logic        ocFaultPin,
    input  wire logic        pwmClkPin,
    input  wire logic        nvmRestore,
    input  wire logic        clearFaults,
    output logic             powerOn,
    output logic             latchedOff,
    output logic [4:0]       ocThreshold,
    output logic [9:0]       stackLimit,
    output logic             statusByteOc,
    output logic             statusByteNone,
    output logic             statusWordIout,
    output logic             statusWordVout,
    output logic             statusIoutOcf,
    output logic             statusVoutUvf,
    output logic             statusCml,
    output logic             statusCmlData,
    output logic             hostAlert
);
    import uv_oc_pkg::*;

    // Link side holding registers stay put while busy, so the core reads them quasi-statically
    logic        reqTgl_q, holdWrite_q, ackS1_q, ackS2_q, ackSeen_q, ackEdge;
    logic [7:0]  holdCode_q, holdPhase_q;
    logic [15:0] holdData_q;
    logic        reqS1_q, reqS2_q, reqSeen_q, reqEdge, ackTgl_q, coreErr_q;
    logic [15:0] coreRsp_q;
    logic [5:0]  pinS1_q, pinS2_q;
    logic        pwmPrev_q, pwmTick, enable, uvS, ocS;
    logic [7:0]  uvAction_q, ocAction_q;
    logic [9:0]  limitQa_q [NPHASE];
    logic [2:0]  phaseCnt;
    logic [1:0]  idx;
    logic [11:0] qaIn, limitMax;
    logic [9:0]  rdQa;
    logic [15:0] rdWord;
    logic        allPhases, cmdOk, doWrite;
    power_state_e state_q, state_d;
    logic [31:0] timer_q, timer_d;
    logic [2:0]  tick_q, tick_d, retryCnt_q, retryCnt_d;
    logic        activeOc_q, activeOc_d, running, uvHit, ocHit;
    logic [7:0]  cfg;
    logic        cfgOc, cfgNow, cfgDly;
    logic [9:0]  minQa;

    function automatic logic [11:0] linToQa(input logic [15:0] w);
        logic signed [5:0] sh;
        logic [5:0]        n;
        logic [31:0]       m;
        logic [31:0]       r;
        sh = $signed({w[EXP_MSB], w[EXP_MSB:EXP_LSB]}) + 6'sd2;
        m  = {21'h0, w[MANT_MSB:0]};
        n  = 6'(-sh);
        if (sh >= 6'sd0) begin
            r = (sh > 6'sd10) ? ((m == 32'h0) ? 32'h0 : 32'hFFFFFFFF) : (m << sh);
        end else begin
            r = m >> n;
            if ((r << n) != m) begin
                r = r + 32'h1;  // Between steps rounds up
            end
        end
        // Negative mantissa or oversize value is flagged in bit 11
        if (w[MANT_MSB] || r > 32'h3FF) begin
            return 12'h800;
        end
        return {2'h0, r[9:0]};
    endfunction : linToQa

    function automatic logic [4:0] qaToAmps(input logic [9:0] qa);
        logic [10:0] a;
        a = ({1'b0, qa} + 11'h3) >> 2;
        if (a < 11'(AMP_MIN)) begin
            return AMP_MIN;
        end
        return (a > 11'(AMP_MAX)) ? AMP_MAX : a[4:0];
    endfunction : qaToAmps

    function automatic logic [2:0] dlyTicks(input logic [2:0] d);
        if (d <= 3'h1) begin
            return DLY_TICKS_SHORT;
        end
        return (d <= 3'h4) ? DLY_TICKS_MID : DLY_TICKS_LONG;
    endfunction : dlyTicks

    // Link clock domain: take a command, wait for the core's answer
    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            reqTgl_q    <= 1'b0;
            holdWrite_q <= 1'b0;
            holdCode_q  <= 8'h00;
            holdPhase_q <= 8'h00;
            holdData_q  <= 16'h0000;
            cmdBusy     <= 1'b0;
            rspValid    <= 1'b0;
            rspError    <= 1'b0;
            rspData     <= 16'h0000;
        end else begin
            if (cmdValid && !cmdBusy) begin
                holdWrite_q <= cmdWrite;
                holdCode_q  <= cmdCode;
                holdPhase_q <= cmdPhase;
                holdData_q  <= cmdData;
                reqTgl_q    <= ~reqTgl_q;
                cmdBusy     <= 1'b1;
            end else if (ackEdge) begin
                cmdBusy <= 1'b0;
            end
            rspValid <= ackEdge;
            if (ackEdge) begin
                rspData  <= coreRsp_q;
                rspError <= coreErr_q;
            end
        end
    end

    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            ackS1_q   <= 1'b0;
            ackS2_q   <= 1'b0;
            ackSeen_q <= 1'b0;
        end else begin
            ackS1_q   <= ackTgl_q;
            ackS2_q   <= ackS1_q;
            ackSeen_q <= ackS2_q;
        end
    end

    assign ackEdge = ackS2_q ^ ackSeen_q;

    // Core domain synchronisers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reqS1_q   <= 1'b0;
            reqS2_q   <= 1'b0;
            reqSeen_q <= 1'b0;
            pinS1_q   <= 6'h00;
            pinS2_q   <= 6'h00;
            pwmPrev_q <= 1'b0;
        end else begin
            reqS1_q   <= reqTgl_q;
            reqS2_q   <= reqS1_q;
            reqSeen_q <= reqS2_q;
            pinS1_q   <= {phaseCountPin, powerEnablePin, uvFaultPin, ocFaultPin, pwmClkPin};
            pinS2_q   <= pinS1_q;
            pwmPrev_q <= pinS2_q[0];
        end
    end

    assign reqEdge = reqS2_q ^ reqSeen_q;
    assign pwmTick = pinS2_q[0] && !pwmPrev_q;
    assign enable  = pinS2_q[3];
    assign uvS     = pinS2_q[2];
    assign ocS     = pinS2_q[1];

    // Command decode and range checks
    always_comb begin
        phaseCnt  = {1'b0, pinS2_q[5:4]} + 3'h1;
        idx       = holdPhase_q[1:0];
        allPhases = holdPhase_q == PHASE_ALL;
        qaIn      = linToQa(holdData_q);
        limitMax  = allPhases ? 12'(QA_STACK_MAX * phaseCnt) : {2'h0, QA_PHASE_MAX};
        rdQa      = allPhases ? 10'(limitQa_q[0] * phaseCnt) : limitQa_q[idx];
        cmdOk     = 1'b0;
        rdWord    = 16'h0000;
        case (holdCode_q)
            CMD_UV_ACTION: begin
                cmdOk  = !holdWrite_q || holdData_q[ACT_MSB:ACT_LSB] != UV_INVALID;
                rdWord = {8'h00, uvAction_q};
            end
            CMD_OC_LIMIT: begin
                cmdOk  = (allPhases || holdPhase_q < PHASE_LIMIT)
                         && (!holdWrite_q || (!qaIn[11] && qaIn <= limitMax));
                rdWord = {OC_EXP_RESET, 1'b0, rdQa};
            end
            CMD_OC_ACTION: begin
                cmdOk  = !holdWrite_q || holdData_q[ACT_MSB:ACT_LSB] != OC_INVALID;
                rdWord = {8'h00, ocAction_q};
            end
            default: begin
                cmdOk = 1'b0;
            end
        endcase
        doWrite = reqEdge && holdWrite_q && cmdOk;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ackTgl_q  <= 1'b0;
            coreErr_q <= 1'b0;
            coreRsp_q <= 16'h0000;
        end else if (reqEdge) begin
            ackTgl_q  <= ~ackTgl_q;
            coreErr_q <= !cmdOk;
            coreRsp_q <= holdWrite_q ? 16'h0000 : rdWord;
        end
    end

    // Response bytes; overcurrent delay bits are read-only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            uvAction_q <= UV_ACTION_RESET;
            ocAction_q <= OC_ACTION_RESET;
        end else if (doWrite && holdCode_q == CMD_UV_ACTION) begin
            uvAction_q <= holdData_q[7:0];
        end else if (doWrite && holdCode_q == CMD_OC_ACTION) begin
            ocAction_q <= {holdData_q[ACT_MSB:RETRY_LSB], ocAction_q[DLY_MSB:DLY_LSB]};
        end
    end

    // Per-phase limits in quarter amperes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NPHASE; i++) begin
                limitQa_q[i] <= OC_LIMIT_RESET_QA;
            end
        end else if (doWrite && holdCode_q == CMD_OC_LIMIT) begin
            if (allPhases) begin
                for (int i = 0; i < NPHASE; i++) begin
                    limitQa_q[i] <= 10'(qaIn / {9'h000, phaseCnt});
                end
            end else begin
                limitQa_q[idx] <= qaIn[9:0];
            end
        end else if (nvmRestore) begin
            for (int i = 0; i < NPHASE; i++) begin
                limitQa_q[i] <= (limitQa_q[i] > QA_PHASE_MAX) ? QA_PHASE_MAX : limitQa_q[i];
            end
        end
    end

    // Lowest limit over the populated phases
    always_comb begin
        minQa = limitQa_q[0];
        for (int i = 1; i < NPHASE; i++) begin
            if (3'(i) < phaseCnt && limitQa_q[i] < minQa) begin
                minQa = limitQa_q[i];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ocThreshold <= AMP_MIN;
            stackLimit  <= 10'h000;
        end else begin
            ocThreshold <= qaToAmps(limitQa_q[0]);
            stackLimit  <= 10'(minQa * phaseCnt);
        end
    end

    // Shutdown and retry sequencer
    assign running = state_q == ST_START || state_q == ST_RUN;
    assign uvHit   = running && enable && uvS;
    assign ocHit   = running && enable && ocS;

    always_comb begin
        // Overcurrent takes priority when both faults appear together
        cfgOc      = running ? ocHit : activeOc_q;
        cfg        = cfgOc ? ocAction_q : uvAction_q;
        cfgNow     = cfgOc ? cfg[ACT_MSB:ACT_LSB] == OC_NOW     : cfg[ACT_MSB:ACT_LSB] == UV_NOW;
        cfgDly     = cfgOc ? cfg[ACT_MSB:ACT_LSB] == OC_DELAYED : cfg[ACT_MSB:ACT_LSB] == UV_DELAYED;
        state_d    = state_q;
        timer_d    = timer_q + 32'h1;
        tick_d     = tick_q;
        retryCnt_d = retryCnt_q;
        activeOc_d = activeOc_q;
        if (!enable) begin
            state_d    = ST_OFF;
            retryCnt_d = 3'h0;
        end else begin
            case (state_q)
                ST_OFF: begin
                    state_d = ST_START;
                    timer_d = 32'h0;
                end
                ST_START, ST_RUN: begin
                    if ((uvHit || ocHit) && cfgDly) begin
                        state_d    = ST_DELAY;
                        tick_d     = 3'h0;
                        activeOc_d = cfgOc;
                    end else if ((uvHit || ocHit) && cfgNow) begin
                        state_d    = ST_LATCH;
                        activeOc_d = cfgOc;
                    end else if (state_q == ST_START && timer_q >= 32'(RISE_CYCLES - 1)) begin
                        state_d    = ST_RUN;
                        retryCnt_d = 3'h0;
                    end
                end
                ST_DELAY: begin
                    if (!(activeOc_q ? ocS : uvS)) begin
                        state_d = ST_RUN;
                    end else if (pwmTick) begin
                        tick_d = tick_q + 3'h1;
                        if (tick_q + 3'h1 >= dlyTicks(cfg[DLY_MSB:DLY_LSB])) begin
                            state_d = ST_LATCH;
                        end
                    end
                end
                ST_WAIT: begin
                    if (timer_q >= 32'(cfg[DLY_MSB:DLY_LSB] <= 3'h1 ? 3'h1 : cfg[DLY_MSB:DLY_LSB])
                                   * 32'(RISE_CYCLES) - 32'h1) begin
                        state_d = ST_START;
                        timer_d = 32'h0;
                    end
                end
                ST_LATCH: begin
                    state_d = ST_LATCH;
                end
                default: begin
                    state_d = ST_OFF;
                end
            endcase
            // A shutdown lands in latch state first and is turned into a retry here
            if (state_d == ST_LATCH && state_q != ST_LATCH) begin
                timer_d = 32'h0;
                if (cfg[RETRY_MSB:RETRY_LSB] == RETRY_NONE) begin
                    state_d = ST_LATCH;
                end else if (cfg[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER) begin
                    state_d = ST_WAIT;
                end else if (retryCnt_q < cfg[RETRY_MSB:RETRY_LSB]) begin
                    state_d    = ST_WAIT;
                    retryCnt_d = retryCnt_q + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= ST_OFF;
            timer_q    <= 32'h0;
            tick_q     <= 3'h0;
            retryCnt_q <= 3'h0;
            activeOc_q <= 1'b0;
            powerOn    <= 1'b0;
            latchedOff <= 1'b0;
        end else begin
            state_q    <= state_d;
            timer_q    <= timer_d;
            tick_q     <= tick_d;
            retryCnt_q <= retryCnt_d;
            activeOc_q <= activeOc_d;
            powerOn    <= state_d == ST_START || state_d == ST_RUN || state_d == ST_DELAY;
            latchedOff <= state_d == ST_LATCH;
        end
    end

    // Sticky status; a new event in the clearing cycle wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            statusByteOc   <= 1'b0;
            statusWordIout <= 1'b0;
            statusIoutOcf  <= 1'b0;
            statusByteNone <= 1'b0;
            statusWordVout <= 1'b0;
            statusVoutUvf  <= 1'b0;
            statusCml      <= 1'b0;
            statusCmlData  <= 1'b0;
            hostAlert      <= 1'b0;
        end else begin
            statusByteOc   <= ocHit || (statusByteOc && !clearFaults);
            statusWordIout <= ocHit || (statusWordIout && !clearFaults);
            statusIoutOcf  <= ocHit || (statusIoutOcf && !clearFaults);
            statusByteNone <= uvHit || (statusByteNone && !clearFaults);
            statusWordVout <= uvHit || (statusWordVout && !clearFaults);
            statusVoutUvf  <= uvHit || (statusVoutUvf && !clearFaults);
            statusCml      <= (reqEdge && !cmdOk) || (statusCml && !clearFaults);
            statusCmlData  <= (reqEdge && !cmdOk) || (statusCmlData && !clearFaults);
            hostAlert      <= ocHit || uvHit || (reqEdge && !cmdOk)
                              || ((statusIoutOcf || statusVoutUvf || statusCml) && !clearFaults);
        end
    end

    a_uv_now_off: assert property (@(posedge clk) disable iff (!reset_n)
        uvHit && !ocS && uvAction_q[ACT_MSB:ACT_LSB] == UV_NOW |=> !powerOn)
        else $error("undervoltage immediate shutdown missed");
    a_zero_retry_latch: assert property (@(posedge clk) disable iff (!reset_n)
        ocHit && ocAction_q[ACT_MSB:ACT_LSB] == OC_NOW && ocAction_q[RETRY_MSB:RETRY_LSB] == 3'h0
        |=> latchedOff && !powerOn)
        else $error("zero retry did not latch off");
    a_retry_exhausted: assert property (@(posedge clk) disable iff (!reset_n)
        ocHit && ocAction_q[ACT_MSB:ACT_LSB] == OC_NOW && ocAction_q[RETRY_MSB:RETRY_LSB] != 3'h7
        && retryCnt_q >= ocAction_q[RETRY_MSB:RETRY_LSB] |=> latchedOff)
        else $error("retry count exceeded without latch");
    a_retry_forever: assert property (@(posedge clk) disable iff (!reset_n)
        ocHit && ocAction_q[ACT_MSB:ACT_LSB] == OC_NOW && ocAction_q[RETRY_MSB:RETRY_LSB] == 3'h7
        |=> state_q == ST_WAIT && !latchedOff)
        else $error("unlimited retry latched off");
    a_delay_ticks: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_DELAY && !activeOc_q |-> tick_q < dlyTicks(uvAction_q[DLY_MSB:DLY_LSB]))
        else $error("shutdown delay overran");
    a_oc_ignore: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_RUN && ocHit && !uvS && ocAction_q[ACT_MSB:ACT_LSB] == 2'h0
        |=> state_q == ST_RUN && powerOn)
        else $error("ignored overcurrent stopped the output");
    a_invalid_flag: assert property (@(posedge clk) disable iff (!reset_n)
        reqEdge && !cmdOk |=> statusCmlData && statusCml && hostAlert)
        else $error("invalid data not flagged");
    a_oc_status: assert property (@(posedge clk) disable iff (!reset_n)
        ocHit |=> statusByteOc && statusWordIout && statusIoutOcf && hostAlert)
        else $error("overcurrent status not set");
    a_uv_status: assert property (@(posedge clk) disable iff (!reset_n)
        uvHit |=> statusByteNone && statusWordVout && statusVoutUvf)
        else $error("undervoltage status not set");
    a_retry_cleared: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == ST_OFF || state_q == ST_RUN |-> retryCnt_q == 3'h0 || $past(state_q) == ST_RUN)
        else $error("retry counter not cleared");
    a_threshold_floor: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 ocThreshold >= AMP_MIN && ocThreshold <= AMP_MAX)
        else $error("threshold out of hardware range");
    a_rsp_pulse: assert property (@(posedge linkClk) disable iff (!reset_n)
        rspValid |-> !cmdBusy ##1 !rspValid)
        else $error("answer strobe longer than one cycle");

endmodule : uv_oc_fault_limit_response

// [src/uv_oc_pkg.sv]
// Constants for the undervoltage / overcurrent fault limit and response block
package uv_oc_pkg;

    // Command codes and phase selector
    localparam logic [7:0] CMD_UV_ACTION  = 8'h45;
    localparam logic [7:0] CMD_OC_LIMIT   = 8'h46;
    localparam logic [7:0] CMD_OC_ACTION  = 8'h47;
    localparam logic [7:0] PHASE_ALL      = 8'hFF;
    localparam logic [7:0] PHASE_LIMIT    = 8'h04;
    localparam int         NPHASE         = 4;

    // Response byte field positions
    localparam int ACT_MSB   = 7;
    localparam int ACT_LSB   = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DLY_MSB   = 2;
    localparam int DLY_LSB   = 0;

    // Limit word field positions
    localparam int EXP_MSB  = 15;
    localparam int EXP_LSB  = 11;
    localparam int MANT_MSB = 10;

    // Action codes
    localparam logic [1:0] UV_DELAYED = 2'h1;
    localparam logic [1:0] UV_NOW     = 2'h2;
    localparam logic [1:0] UV_INVALID = 2'h3;
    localparam logic [1:0] OC_INVALID = 2'h1;
    localparam logic [1:0] OC_DELAYED = 2'h2;
    localparam logic [1:0] OC_NOW     = 2'h3;
    localparam logic [2:0] RETRY_NONE    = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // Reset values (stand-ins for the nonvolatile copy)
    localparam logic [7:0] UV_ACTION_RESET  = 8'h80;
    localparam logic [7:0] OC_ACTION_RESET  = 8'hC0;
    localparam logic [4:0] OC_EXP_RESET     = 5'h1E;
    localparam logic [9:0] OC_LIMIT_RESET_QA = 10'h078;

    // Limits in quarter amperes, threshold steps in amperes
    localparam logic [9:0] QA_PHASE_MAX = 10'h07C;
    localparam logic [9:0] QA_STACK_MAX = 10'h0F8;
    localparam logic [4:0] AMP_MIN      = 5'h04;
    localparam logic [4:0] AMP_MAX      = 5'h1F;

    // Shutdown delays in switching clock periods
    localparam logic [2:0] DLY_TICKS_SHORT = 3'h1;
    localparam logic [2:0] DLY_TICKS_MID   = 3'h3;
    localparam logic [2:0] DLY_TICKS_LONG  = 3'h7;

    // Soft-start rise time
    localparam int CLK_PERIOD_NS           = 4;
    localparam int SOFT_START_RISE_TIME_NS = 1000000;
    localparam int SOFT_START_RISE_CYCLES  = SOFT_START_RISE_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [5:0] {
        ST_OFF   = 6'h01,
        ST_START = 6'h02,
        ST_RUN   = 6'h04,
        ST_DELAY = 6'h08,
        ST_WAIT  = 6'h10,
        ST_LATCH = 6'h20
    } power_state_e;

endpackage : uv_oc_pkg

// [tb/host_link_model.sv]
// Host model issuing one transfer at a time on the command link
`timescale 1ns/1ns
module host_link_model (
    input  wire logic        linkClk,
    input  wire logic        rspValid,
    input  wire logic        rspError,
    input  wire logic [15:0] rspData,
    output logic             cmdValid = 1'b0,
    output logic             cmdWrite = 1'b0,
    output logic [7:0]       cmdCode = 8'h00,
    output logic [7:0]       cmdPhase = 8'h00,
    output logic [15:0]      cmdData = 16'h0000
);
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] p,
                        input logic [15:0] d, output logic [15:0] rd, output logic er,
                        output logic ok);
        int n;
        ok = 1'b0;
        @(posedge linkClk);
        cmdValid <= 1'b1;
        cmdWrite <= w;
        cmdCode  <= c;
        cmdPhase <= p;
        cmdData  <= d;
        @(posedge linkClk);
        cmdValid <= 1'b0;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge linkClk);
            ok = (rspValid === 1'b1);
        end
        rd = rspData;
        er = rspError;
        // Released lines must not keep looking valid
        cmdCode <= ~c;
        cmdData <= ~d;
    endtask : xfer
endmodule : host_link_model

// [tb/tb_uv_oc_fault_limit_response.sv]
// Self-checking bench for the fault limit and response block
`timescale 1ns/1ns
module tb_uv_oc_fault_limit_response;
    import uv_oc_pkg::*;
    logic clk = 1'b0, linkClk = 1'b0, reset_n = 1'b0, powerEnablePin = 1'b0;
    logic uvFaultPin = 1'b0, ocFaultPin = 1'b0, nvmRestore = 1'b0, clearFaults = 1'b0;
    logic [1:0] phaseCountPin = 2'h3;
    logic [3:0] pwmCnt = 4'h0;
    logic pwmClkPin, cmdValid, cmdWrite, cmdBusy, rspValid, rspError, powerOn, latchedOff;
    logic statusByteOc, statusByteNone, statusWordIout, statusWordVout, statusIoutOcf;
    logic statusVoutUvf, statusCml, statusCmlData, hostAlert, er, ok;
    logic [7:0] cmdCode, cmdPhase;
    logic [15:0] cmdData, rspData, rd;
    logic [4:0] ocThreshold;
    logic [9:0] stackLimit;
    int errTotal = 0, checks = 0, uvB = 'h80, ocB = 'hC0, bad = 0, q, v, n;
    int lim[4];
    always #2 clk = ~clk;
    initial #7 forever #15 linkClk = ~linkClk;
    always @(posedge clk) pwmCnt <= pwmCnt + 4'h1;
    assign pwmClkPin = pwmCnt[3];
    uv_oc_fault_limit_response #(.RISE_CYCLES(20)) dut (.*);
    host_link_model host (.*);
    task automatic finishTest();
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finishTest
    task automatic chkData(string what, int exp, logic [15:0] got);
        checks++;
        if (got !== 16'(exp)) begin
            errTotal++;
            $display("unexpected %s: expected %h seen %h", what, 16'(exp), got);
        end
    endtask : chkData
    task automatic chkFlag(string what, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : chkFlag
    task automatic cmd(logic w, logic [7:0] c, logic [7:0] p, logic [15:0] d);
        host.xfer(w, c, p, d, rd, er, ok);
        chkFlag("answer", 1'b1, ok);
        chkFlag("busy", 1'b0, cmdBusy);
        if (!ok) finishTest();
    endtask : cmd
    task automatic waitPower();
        for (n = 0; n < 60 && powerOn !== 1'b1; n++) @(posedge clk);
        chkFlag("power on", 1'b1, powerOn);
    endtask : waitPower
    initial begin
        #200000;
        errTotal++;
        finishTest();
    end
    initial begin
        void'($urandom(19));
        repeat (3) @(posedge linkClk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            cmd(1'b1, CMD_UV_ACTION, 8'h00, v[15:0]);
            chkFlag("uv reject", v[7:6] == 2'h3, er);
            bad |= (v[7:6] == 2'h3) | (v[23:22] == 2'h1);
            if (v[7:6] != 2'h3) uvB = v[7:0];
            cmd(1'b1, CMD_OC_ACTION, 8'h00, v[31:16]);
            chkFlag("oc reject", v[23:22] == 2'h1, er);
            if (v[23:22] != 2'h1) ocB = {v[23:19], ocB[2:0]};
            cmd(1'b0, CMD_UV_ACTION, 8'h00, 16'h0000);
            chkData("uv byte", uvB, rd);
            cmd(1'b0, CMD_OC_ACTION, 8'h00, 16'h0000);
            chkData("oc byte", ocB, rd);
        end
        chkFlag("data error", bad != 0, statusCmlData & statusCml);
        $display("test response bytes done");
        q = $urandom_range(200, 4);
        cmd(1'b1, CMD_OC_LIMIT, PHASE_ALL, 16'hF000 | 16'(q));
        foreach (lim[i]) lim[i] = q / 4;
        cmd(1'b1, CMD_OC_LIMIT, 8'h02, 16'hF07C);
        lim[2] = 124;
        chkFlag("limit accept", 1'b0, er);
        cmd(1'b1, CMD_OC_LIMIT, 8'h03, 16'hF07D);
        chkFlag("limit reject", 1'b1, er);
        for (int p = 0; p < 4; p++) begin
            cmd(1'b0, CMD_OC_LIMIT, 8'(p), 16'h0000);
            chkData("phase limit", 'hF000 | lim[p], rd);
        end
        cmd(1'b0, CMD_OC_LIMIT, PHASE_ALL, 16'h0000);
        chkData("stack read", 'hF000 | lim[0] * 4, rd);
        chkData("stack limit", lim[0] * 4, 16'(stackLimit));
        n = (lim[0] + 3) / 4;
        chkData("threshold", n < 4 ? 4 : n, 16'(ocThreshold));
        cmd(1'b1, CMD_OC_LIMIT, PHASE_ALL, 16'hF3E0);
        chkFlag("stack accept", 1'b0, er);
        @(posedge clk) nvmRestore <= 1'b1;
        @(posedge clk) nvmRestore <= 1'b0;
        repeat (3) @(posedge clk);
        chkData("restored", 124 * 4, 16'(stackLimit));
        cmd(1'b0, CMD_OC_LIMIT, 8'h01, 16'h0000);
        chkData("restored limit", 'hF07C, rd);
        $display("test limit done");
        cmd(1'b1, CMD_OC_ACTION, 8'h00, 16'h00C0);
        @(posedge clk);
        powerEnablePin <= 1'b1;
        waitPower();
        ocFaultPin <= 1'b1;
        for (n = 0; n < 60 && latchedOff !== 1'b1; n++) @(posedge clk);
        chkFlag("latched", 1'b1, latchedOff);
        chkFlag("power off", 1'b0, powerOn);
        chkFlag("oc flags", 1'b1, statusIoutOcf & statusByteOc & statusWordIout & hostAlert);
        cmd(1'b1, CMD_UV_ACTION, 8'h00, 16'h0000);
        @(posedge clk);
        ocFaultPin <= 1'b0;
        powerEnablePin <= 1'b0;
        clearFaults <= 1'b1;
        repeat (5) @(posedge clk);
        clearFaults <= 1'b0;
        powerEnablePin <= 1'b1;
        waitPower();
        uvFaultPin <= 1'b1;
        repeat (10) @(posedge clk);
        chkFlag("uv flags", 1'b1, statusVoutUvf & statusWordVout & statusByteNone);
        chkFlag("uv ignored", 1'b1, powerOn);
        cmd(1'b1, CMD_UV_ACTION, 8'h00, 16'h0052);
        repeat (100) @(posedge clk);
        chkFlag("uv retrying", 1'b0, latchedOff);
        for (n = 0; n < 150 && latchedOff !== 1'b1; n++) @(posedge clk);
        chkFlag("uv retry latch", 1'b1, latchedOff);
        cmd(1'b1, CMD_OC_ACTION, 8'h00, 16'h00F8);
        @(posedge clk);
        ocFaultPin <= 1'b1;
        powerEnablePin <= 1'b0;
        repeat (5) @(posedge clk);
        powerEnablePin <= 1'b1;
        repeat (200) @(posedge clk);
        chkFlag("oc retry forever", 1'b0, latchedOff);
        $display("test faults done");
        finishTest();
    end
endmodule : tb_uv_oc_fault_limit_response
